// [acpw_pkg.sv]
// Package with register map, field positions and reset values for the auxiliary configuration and wake block.
package acpw_pkg;
	localparam logic [7:0] OFS_PIN_ROUTING = 8'hc0;
	localparam logic [7:0] OFS_FORCED_CHG  = 8'hc1;
	localparam logic [7:0] OFS_RATE_SHADOW = 8'hc2;
	localparam logic [7:0] OFS_SER1_SHADOW = 8'hc3;
	localparam logic [7:0] OFS_SER2_SHADOW = 8'hc4;
	localparam logic [7:0] OFS_WAKE_OUTCTL = 8'hc5;
	localparam logic [7:0] OFS_WAKE_EVSTAT = 8'hc6;
	localparam logic [7:0] OFS_WAKE_SRCSTS = 8'hc7;
	localparam logic [7:0] OFS_WAKE_SRCEN  = 8'hc8;
	localparam logic [7:0] OFS_IRQ_STATUS  = 8'hd0;
	localparam logic [7:0] OFS_IRQ_MASK    = 8'hd1;
	localparam logic [7:0] RST_PIN_ROUTING = 8'h02;
	localparam logic [7:0] RST_FORCED_CHG  = 8'h03;
	localparam logic [7:0] RST_ZERO        = 8'h00;
	localparam int BIT_DMA3_SEL   = 1;
	localparam int BIT_KBC_SEL    = 3;
	localparam int BIT_FORCE_CHG  = 0;
	localparam int BIT_DISK_CHANGE_BIT     = 7;
	localparam int BIT_PME_OUTPUT_ENABLE     = 0;
	localparam int BIT_PME_FLAG   = 0;
	localparam logic [7:0] PIN_ROUTING_MASK = 8'h0a;
	localparam logic [7:0] RATE_MASK        = 8'hdf;
	localparam logic [7:0] FIFO_CTRL_MASK   = 8'hcf;
	localparam logic [7:0] WAKE_SRC_MASK    = 8'h1e;
	localparam int IRQ_WAKE_SRC  = 0;
	localparam int IRQ_PME_FLAG  = 1;
	localparam int IRQ_FORCE_CLR = 2;
	localparam logic [2:0] IRQ_MASK_BITS = 3'h7;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage : acpw_pkg

// [acpw_aux_wake.sv]
// Auxiliary configuration registers with forced disk change latch, write-only shadows and wake event logic.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps

// ************************************************************
// Block top level.
// ************************************************************
// Summary of operation
// - Software may set forced media change by writing 1; writing 0 is ignored.
// - Step pulse with drive select 0 active clears forced media change.
// - Disk change bit 7 is disk_change_in_n OR (drive_select0_n AND forced change).
// - Floppy rate shadow returns last rate, write_sel_a, power-down and soft reset.
// - Each serial FIFO control shadow readable: enable, resets, DMA mode, threshold.
// - Wake output drives only when pme_output_enable is 1; default 0 suppresses it.
// - pme_output_enable resets only on standby_rail power-on.
// - pme_event_flag sets on any enabled wake condition, regardless of output enable.
// - Writing 1 clears pme_event_flag and releases the output; 0 does nothing.
// - pme_event_flag survives main-supply, soft and hard resets.
// - Each source event latches its wake status bit regardless of enables.
// - Writing 1 clears a wake status bit; writing 0 leaves it.
// - Output asserts for a source only if enabled, event raised and output enabled.
// - Disabled sources still record status but never assert the output.
// - Wake status and enable reset only on standby_rail power-on.
module acpw_aux_wake (
	input  wire logic       clk,                 // System clock, 25 MHz.
	input  wire logic       rstn,                // Main supply reset, active low.
	input  wire logic       standby_rstn,        // Standby rail power-on reset, active low.
	input  wire logic [7:0] avs_address,         // Register index.
	input  wire logic       avs_read,            // Read request.
	input  wire logic       avs_write,           // Write request.
	input  wire logic [7:0] avs_writedata,       // Write data.
	output logic      [7:0] avs_readdata,        // Read data.
	output logic            avs_waitrequest,     // Stall, low when answered.
	input  wire logic       step_pulse_n,        // Floppy step pin, active low.
	input  wire logic       drive_select0_n,     // Drive select 0 pin, active low.
	input  wire logic       disk_change_in_n,    // Disk change pin.
	input  wire logic       rate_wr,             // Floppy rate register write strobe.
	input  wire logic [7:0] rate_wdata,          // Floppy rate write value.
	input  wire logic       ser1_fifo_wr,        // Serial 1 FIFO control write strobe.
	input  wire logic       ser2_fifo_wr,        // Serial 2 FIFO control write strobe.
	input  wire logic [7:0] fifo_wdata,          // FIFO control write value.
	input  wire logic [4:1] wake_event,          // Wake source levels: ring2, ring1, keyboard, mouse.
	output logic            disk_change_bit,     // Digital input bit 7.
	output logic            dma3_route_sel,      // 1 selects default DMA 3 pins.
	output logic            kbc_pin_route_sel,   // 1 selects keyboard-controller pin functions.
	output logic            pme_n_out,           // Wake output level, low asserts.
	output logic            pme_n_oe,            // Wake output enable, open drain.
	output logic            irq                  // Level interrupt.
);
	// ************************************************************
	// Reset release and input synchronisers.
	// ************************************************************
	logic [1:0] rst_sync_r;
	logic [1:0] sb_sync_r;
	logic       rst_n_i;
	logic       sb_n_i;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end

	always_ff @(posedge clk or negedge standby_rstn) begin
		if (!standby_rstn) begin
			sb_sync_r <= 2'h0;
		end else begin
			sb_sync_r <= {sb_sync_r[0], 1'b1};
		end
	end

	assign rst_n_i = rst_sync_r[1];
	assign sb_n_i  = sb_sync_r[1];

	logic [6:0] pin_s1_r;
	logic [6:0] pin_s2_r;
	logic       step_prev_r;

	// Pins enter the first flop untouched, so nothing but the second flop reads a metastable value.
	always_ff @(posedge clk or negedge sb_n_i) begin
		if (!sb_n_i) begin
			pin_s1_r    <= 7'h07;
			pin_s2_r    <= 7'h07;
			step_prev_r <= 1'b1;
		end else begin
			pin_s1_r    <= {wake_event, disk_change_in_n, drive_select0_n, step_pulse_n};
			pin_s2_r    <= pin_s1_r;
			step_prev_r <= pin_s2_r[0];
		end
	end

	logic       step_fall;
	logic       ds0_n_s;
	logic       disk_change_bit_n_s;
	logic [4:1] wake_s;
	logic [4:1] wake_prev_r;
	logic [4:1] wake_rise;

	assign step_fall  = step_prev_r & ~pin_s2_r[0];
	assign ds0_n_s    = pin_s2_r[1];
	assign disk_change_bit_n_s = pin_s2_r[2];
	assign wake_s     = pin_s2_r[6:3];

	always_ff @(posedge clk or negedge sb_n_i) begin
		if (!sb_n_i) begin
			wake_prev_r <= 4'h0;
		end else begin
			wake_prev_r <= wake_s;
		end
	end

	assign wake_rise = wake_s & ~wake_prev_r;

	// ************************************************************
	// Bus decode. Every access is answered one cycle after it is raised.
	// ************************************************************
	logic       ack_r;
	logic       wr_hit;
	logic [7:0] wd;

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (avs_read | avs_write) & ~ack_r;
		end
	end

	assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
	assign wr_hit          = avs_write & ack_r;
	assign wd              = avs_writedata;

	function automatic logic wr_at(input logic hit, input logic [7:0] a, input logic [7:0] ofs);
		return hit && (a == ofs);
	endfunction

	// ************************************************************
	// Main-supply registers.
	// ************************************************************
	logic [7:0] pin_routing_r;
	logic       force_chg_r;
	logic [7:0] rate_shadow_r;
	logic [7:0] ser1_shadow_r;
	logic [7:0] ser2_shadow_r;
	logic       force_set;
	logic       force_clr;

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_routing_r <= acpw_pkg::RST_PIN_ROUTING;
		end else if (wr_at(wr_hit, avs_address, acpw_pkg::OFS_PIN_ROUTING)) begin
			pin_routing_r <= wd & acpw_pkg::PIN_ROUTING_MASK;
		end
	end

	assign dma3_route_sel    = pin_routing_r[acpw_pkg::BIT_DMA3_SEL];
	assign kbc_pin_route_sel = pin_routing_r[acpw_pkg::BIT_KBC_SEL];

	assign force_set = wr_at(wr_hit, avs_address, acpw_pkg::OFS_FORCED_CHG) && wd[acpw_pkg::BIT_FORCE_CHG];
	assign force_clr = step_fall & ~ds0_n_s;

	// A write and a step in one cycle leave the bit set, so a software request is never lost.
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			force_chg_r <= acpw_pkg::RST_FORCED_CHG[acpw_pkg::BIT_FORCE_CHG];
		end else if (force_set) begin
			force_chg_r <= 1'b1;
		end else if (force_clr) begin
			force_chg_r <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			disk_change_bit <= 1'b0;
		end else begin
			disk_change_bit <= disk_change_bit_n_s | (ds0_n_s & force_chg_r);
		end
	end

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rate_shadow_r <= acpw_pkg::RST_ZERO;
			ser1_shadow_r <= acpw_pkg::RST_ZERO;
			ser2_shadow_r <= acpw_pkg::RST_ZERO;
		end else begin
			if (rate_wr) begin
				rate_shadow_r <= rate_wdata & acpw_pkg::RATE_MASK;
			end
			if (ser1_fifo_wr) begin
				ser1_shadow_r <= fifo_wdata & acpw_pkg::FIFO_CTRL_MASK;
			end
			if (ser2_fifo_wr) begin
				ser2_shadow_r <= fifo_wdata & acpw_pkg::FIFO_CTRL_MASK;
			end
		end
	end

	// ************************************************************
	// Standby-rail wake registers.
	// ************************************************************
	// The main reset never reaches these registers; only the standby reset clears them.
	logic       pme_output_enable_r;
	logic       pme_flag_r;
	logic [4:1] wake_sts_r;
	logic [4:1] wake_en_r;
	logic       wake_cond;
	logic       flag_clr;

	always_ff @(posedge clk or negedge sb_n_i) begin
		if (!sb_n_i) begin
			pme_output_enable_r  <= 1'b0;
			wake_en_r <= 4'h0;
		end else begin
			if (wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_OUTCTL)) begin
				pme_output_enable_r <= wd[acpw_pkg::BIT_PME_OUTPUT_ENABLE];
			end
			if (wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_SRCEN)) begin
				wake_en_r <= wd[4:1];
			end
		end
	end

	always_ff @(posedge clk or negedge sb_n_i) begin
		if (!sb_n_i) begin
			wake_sts_r <= 4'h0;
		end else if (wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_SRCSTS)) begin
			wake_sts_r <= (wake_sts_r & ~wd[4:1]) | wake_rise;
		end else begin
			wake_sts_r <= wake_sts_r | wake_rise;
		end
	end

	assign wake_cond = |(wake_rise & wake_en_r);
	assign flag_clr  = wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_EVSTAT) && wd[acpw_pkg::BIT_PME_FLAG];

	always_ff @(posedge clk or negedge sb_n_i) begin
		if (!sb_n_i) begin
			pme_flag_r <= 1'b0;
		end else if (wake_cond) begin
			pme_flag_r <= 1'b1;
		end else if (flag_clr) begin
			pme_flag_r <= 1'b0;
		end
	end

	// Open-drain wake output only pulls low, never drives high.
	assign pme_n_out = 1'b0;
	assign pme_n_oe  = pme_flag_r & pme_output_enable_r;

	// ************************************************************
	// Interrupt status and mask.
	// ************************************************************
	logic [2:0] irq_sts_r;
	logic [2:0] irq_mask_r;
	logic [2:0] irq_set;

	// A new event wins over a clear written in the same cycle, so no event is lost.
	assign irq_set = {force_clr & force_chg_r, wake_cond, |wake_rise};

	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_sts_r  <= 3'h0;
			irq_mask_r <= 3'h0;
		end else begin
			if (wr_at(wr_hit, avs_address, acpw_pkg::OFS_IRQ_STATUS)) begin
				irq_sts_r <= (irq_sts_r & ~wd[2:0]) | irq_set;
			end else begin
				irq_sts_r <= irq_sts_r | irq_set;
			end
			if (wr_at(wr_hit, avs_address, acpw_pkg::OFS_IRQ_MASK)) begin
				irq_mask_r <= wd[2:0] & acpw_pkg::IRQ_MASK_BITS;
			end
		end
	end

	assign irq = |(irq_sts_r & irq_mask_r);

	// ************************************************************
	// Read data.
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n_i) begin
		if (!rst_n_i) begin
			avs_readdata <= 8'h00;
		end else if (avs_read && !ack_r) begin
			unique case (avs_address)
				acpw_pkg::OFS_PIN_ROUTING: avs_readdata <= pin_routing_r;
				acpw_pkg::OFS_FORCED_CHG:  avs_readdata <= {7'h00, force_chg_r};
				acpw_pkg::OFS_RATE_SHADOW: avs_readdata <= rate_shadow_r;
				acpw_pkg::OFS_SER1_SHADOW: avs_readdata <= ser1_shadow_r;
				acpw_pkg::OFS_SER2_SHADOW: avs_readdata <= ser2_shadow_r;
				acpw_pkg::OFS_WAKE_OUTCTL: avs_readdata <= {7'h00, pme_output_enable_r};
				acpw_pkg::OFS_WAKE_EVSTAT: avs_readdata <= {7'h00, pme_flag_r};
				acpw_pkg::OFS_WAKE_SRCSTS: avs_readdata <= {3'h0, wake_sts_r, 1'b0};
				acpw_pkg::OFS_WAKE_SRCEN:  avs_readdata <= {3'h0, wake_en_r, 1'b0};
				acpw_pkg::OFS_IRQ_STATUS:  avs_readdata <= {5'h00, irq_sts_r};
				acpw_pkg::OFS_IRQ_MASK:    avs_readdata <= {5'h00, irq_mask_r};
				default:                   avs_readdata <= acpw_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// ************************************************************
	// Checks.
	// ************************************************************
	force_write_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		force_set |=> force_chg_r)
		else $error("forced change not set by write");
	force_hold_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		(force_chg_r && !force_clr) |=> force_chg_r)
		else $error("forced change cleared without step");
	step_clear_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		(force_clr && !force_set) |=> !force_chg_r)
		else $error("step did not clear forced change");
	disk_change_bit_calc_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		1'b1 |=> disk_change_bit == $past(disk_change_bit_n_s | (ds0_n_s & force_chg_r)))
		else $error("disk change bit wrong");
	rate_copy_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		rate_wr |=> rate_shadow_r == ($past(rate_wdata) & acpw_pkg::RATE_MASK))
		else $error("rate shadow not updated");
	ser_copy_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		ser1_fifo_wr |=> ser1_shadow_r == ($past(fifo_wdata) & acpw_pkg::FIFO_CTRL_MASK))
		else $error("serial shadow not updated");
	ser2_copy_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		ser2_fifo_wr |=> ser2_shadow_r == ($past(fifo_wdata) & acpw_pkg::FIFO_CTRL_MASK))
		else $error("second serial shadow not updated");
	pme_gate_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		!pme_output_enable_r |-> !pme_n_oe)
		else $error("wake output driven while disabled");
	out_enable_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_OUTCTL) |=> pme_output_enable_r == $past(wd[acpw_pkg::BIT_PME_OUTPUT_ENABLE]))
		else $error("output enable not written");
	flag_set_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		wake_cond |=> pme_flag_r)
		else $error("event flag not set");
	flag_clear_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		(flag_clr && !wake_cond) |=> !pme_flag_r && !pme_n_oe)
		else $error("event flag not cleared");
	sts_latch_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		wake_rise[4] |=> wake_sts_r[4])
		else $error("wake status not latched");
	sts_w1c_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		(wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_SRCSTS) && wd[3] && !wake_rise[3]) |=> !wake_sts_r[3])
		else $error("wake status not cleared");
	sts_keep_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		(wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_SRCSTS) && wd[4:1] == 4'h0 && wake_rise == 4'h0)
		|=> $stable(wake_sts_r))
		else $error("wake status changed by zero write");
	drive_cause_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		$rose(pme_n_oe) |-> pme_output_enable_r && ($past(wake_cond) || $past(pme_flag_r)))
		else $error("wake output without cause");
	src_drive_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		(|(wake_rise & wake_en_r) && pme_output_enable_r && !wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_OUTCTL))
		|=> pme_n_oe)
		else $error("enabled source did not drive output");
	src_enable_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		wr_at(wr_hit, avs_address, acpw_pkg::OFS_WAKE_SRCEN) |=> wake_en_r == $past(wd[4:1]))
		else $error("wake enable not written");
	masked_src_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		(wake_rise == 4'h2 && !wake_en_r[2] && !pme_flag_r) |=> !pme_flag_r)
		else $error("disabled source raised flag");
	enable_keep_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		!rst_n_i |=> $stable(pme_output_enable_r) && $stable(wake_en_r))
		else $error("standby register lost in main reset");
	flag_keep_a: assert property (@(posedge clk) disable iff (!sb_n_i)
		(!rst_n_i && !wake_cond) |=> $stable(pme_flag_r))
		else $error("event flag lost in main reset");
	route_a: assert property (@(posedge clk) disable iff (!rst_n_i)
		wr_at(wr_hit, avs_address, acpw_pkg::OFS_PIN_ROUTING)
		|=> {kbc_pin_route_sel, dma3_route_sel} == $past({wd[acpw_pkg::BIT_KBC_SEL], wd[acpw_pkg::BIT_DMA3_SEL]}))
		else $error("routing select mismatch");

	wake_out_c: cover property (@(posedge clk) disable iff (!sb_n_i) $rose(pme_n_oe));
	flag_clr_c: cover property (@(posedge clk) disable iff (!sb_n_i) flag_clr && pme_flag_r);
	step_clr_c: cover property (@(posedge clk) disable iff (!rst_n_i) force_clr && force_chg_r);
	masked_c:   cover property (@(posedge clk) disable iff (!sb_n_i) |(wake_rise & ~wake_en_r));
	irq_c:      cover property (@(posedge clk) disable iff (!rst_n_i) $rose(irq));
endmodule // acpw_aux_wake

// [acpw_pme_rx.sv]
// Chipset-side receiver of the shared open-drain wake line.
`timescale 1ns/1ps

// ************************************************************
// Wake line receiver.
// ************************************************************
module acpw_pme_rx (
	input  wire logic clk,       // Chipset clock.
	input  wire logic pme_line,  // Shared wake line, pulled up when released.
	output logic      wake_req   // High while the line is held low.
);
	// The line is registered once, as a chipset input stage would be.
	always_ff @(posedge clk) begin
		wake_req <= !pme_line;
	end
endmodule // acpw_pme_rx

// [tb.sv]
// Self-checking testbench for the auxiliary configuration and wake block.
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end

// ************************************************************
// Bench top level.
// ************************************************************
module tb;
	logic       clk, rstn, standby_rstn, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address, avs_writedata, avs_readdata, rate_wdata, fifo_wdata, rdv;
	logic       step_pulse_n, drive_select0_n, disk_change_in_n, rate_wr, ser1_fifo_wr, ser2_fifo_wr;
	logic [4:1] wake_event;
	logic       disk_change_bit, dma3_route_sel, kbc_pin_route_sel, pme_n_out, pme_n_oe, irq, wake_req;
	wire        pme_line = pme_n_oe ? pme_n_out : 1'b1;
	int         n_mismatch, cmp_count, d, i;
	int         m_pin = 2, m_frc = 1, m_rate, m_s1, m_s2, m_en, m_flag, m_wsts, m_wen, m_ist, m_imsk;

	acpw_aux_wake acpw_aux_wake_inst (.clk(clk), .rstn(rstn), .standby_rstn(standby_rstn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .step_pulse_n(step_pulse_n),
		.drive_select0_n(drive_select0_n), .disk_change_in_n(disk_change_in_n), .rate_wr(rate_wr),
		.rate_wdata(rate_wdata), .ser1_fifo_wr(ser1_fifo_wr), .ser2_fifo_wr(ser2_fifo_wr),
		.fifo_wdata(fifo_wdata), .wake_event(wake_event), .disk_change_bit(disk_change_bit),
		.dma3_route_sel(dma3_route_sel), .kbc_pin_route_sel(kbc_pin_route_sel), .pme_n_out(pme_n_out),
		.pme_n_oe(pme_n_oe), .irq(irq));
	acpw_pme_rx acpw_pme_rx_inst (.clk(clk), .pme_line(pme_line), .wake_req(wake_req));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task report_and_stop;
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// Expected read value of each register, worked out from the model state.
	function automatic int exp_rd(int a);
		case (a)
			acpw_pkg::OFS_PIN_ROUTING: return m_pin;
			acpw_pkg::OFS_FORCED_CHG:  return m_frc;
			acpw_pkg::OFS_RATE_SHADOW: return m_rate;
			acpw_pkg::OFS_SER1_SHADOW: return m_s1;
			acpw_pkg::OFS_SER2_SHADOW: return m_s2;
			acpw_pkg::OFS_WAKE_OUTCTL: return m_en;
			acpw_pkg::OFS_WAKE_EVSTAT: return m_flag;
			acpw_pkg::OFS_WAKE_SRCSTS: return m_wsts;
			acpw_pkg::OFS_WAKE_SRCEN:  return m_wen;
			acpw_pkg::OFS_IRQ_STATUS:  return m_ist;
			acpw_pkg::OFS_IRQ_MASK:    return m_imsk;
			default:                   return 0;
		endcase
	endfunction

	// One bus cycle; the request is held until waitrequest is seen low at a rising edge.
	task automatic bus(input bit is_wr, input logic [7:0] a, input logic [7:0] wd);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !is_wr;
		avs_write <= is_wr;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			n_mismatch++;
			report_and_stop();
		end else begin
			rdv = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
			@(posedge clk);
		end
	endtask

	task automatic wr(input int a, input int v);
		bus(1'b1, 8'(a), 8'(v));
		case (a)
			'hc0: m_pin = v & 'h0a;
			'hc1: m_frc = m_frc | (v & 1);
			'hc5: m_en = v & 1;
			'hc6: m_flag = m_flag & ~v & 1;
			'hc7: m_wsts = m_wsts & ~(v & 'h1e);
			'hc8: m_wen = v & 'h1e;
			'hd0: m_ist = m_ist & ~(v & 7);
			'hd1: m_imsk = v & 7;
			default: ;
		endcase
	endtask

	task automatic rd_chk(input int a);
		bus(1'b0, 8'(a), 8'h00);
		`CHK(rdv, 8'(exp_rd(a)))
	endtask

	task automatic check_all;
		for (int a = 'hc0; a <= 'hc9; a++) rd_chk(a);
		rd_chk('hd0);
		rd_chk('hd1);
		`CHK(pme_n_oe, 1'(m_flag & m_en))
		`CHK(pme_n_out, 1'b0)
		`CHK(wake_req, 1'(m_flag & m_en))
		`CHK(irq, 1'((m_ist & m_imsk) != 0))
	endtask

	// A rising level on one wake source, then its release.
	task automatic ev(input int s);
		wake_event <= 4'(1 << (s - 1));
		repeat (6) @(posedge clk);
		m_wsts = m_wsts | (1 << s);
		m_ist = m_ist | 1;
		if ((m_wen >> s) & 1) begin
			m_flag = 1;
			m_ist = m_ist | 2;
		end
		wake_event <= 4'h0;
		repeat (6) @(posedge clk);
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		{rstn, standby_rstn, avs_read, avs_write, rate_wr, ser1_fifo_wr, ser2_fifo_wr} = '0;
		{avs_address, avs_writedata, rate_wdata, fifo_wdata, wake_event} = '0;
		{step_pulse_n, drive_select0_n, disk_change_in_n} = 3'h7;
		n_mismatch = 0;
		cmp_count = 0;
		d = $urandom(32'hded0);
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		standby_rstn <= 1'b1;
		repeat (3) @(posedge clk);
		check_all();
		for (int a = 'hc2; a <= 'hc4; a++) wr(a, $urandom);
		// Shadow copies of the write-only settings.
		d = $urandom;
		rate_wr <= 1'b1;
		rate_wdata <= 8'(d);
		m_rate = d & 'hdf;
		@(posedge clk);
		d = $urandom;
		rate_wr <= 1'b0;
		ser1_fifo_wr <= 1'b1;
		fifo_wdata <= 8'(d);
		m_s1 = d & 'hcf;
		@(posedge clk);
		d = $urandom;
		ser1_fifo_wr <= 1'b0;
		ser2_fifo_wr <= 1'b1;
		fifo_wdata <= 8'(d);
		m_s2 = d & 'hcf;
		@(posedge clk);
		ser2_fifo_wr <= 1'b0;
		wr('hc0, $urandom);
		check_all();
		`CHK({dma3_route_sel, kbc_pin_route_sel}, {1'(m_pin >> 1), 1'(m_pin >> 3)})
		wr('hc1, 'hfe);
		rd_chk('hc1);
		// Disk change bit for every pin combination, before and after the step clear.
		for (i = 0; i < 8; i++) begin
			if (i == 4) begin
				drive_select0_n <= 1'b0;
				step_pulse_n <= 1'b0;
				repeat (2) @(posedge clk);
				step_pulse_n <= 1'b1;
				repeat (6) @(posedge clk);
				m_frc = 0;
				m_ist = m_ist | 4;
				rd_chk('hc1);
			end
			{disk_change_in_n, drive_select0_n} <= 2'(i);
			repeat (6) @(posedge clk);
			`CHK(disk_change_bit, 1'(((i >> 1) & 1) | (i & m_frc)))
		end
		wr('hc1, 1);
		rd_chk('hc1);
		wr('hd0, 7);
		wr('hd1, 7);
		wr('hc5, 1);
		// Each wake source, enabled on odd indices, cleared by writing ones after zeros.
		for (i = 1; i <= 4; i++) begin
			wr('hc8, ($urandom & 'h1e & ~(1 << i)) | ((i % 2) << i));
			ev(i);
			check_all();
			wr('hc7, 0);
			wr('hc6, 0);
			wr('hd1, 0);
			check_all();
			wr('hd1, 7);
			wr('hc7, 1 << i);
			wr('hc6, 1);
			wr('hd0, 7);
			check_all();
		end
		// Output disabled: flag still set, output suppressed until enabled.
		wr('hc5, 0);
		wr('hc8, 'h1e);
		ev(3);
		check_all();
		wr('hc5, 1);
		repeat (2) @(posedge clk);
		check_all();
		// Main reset leaves the wake registers alone.
		rstn <= 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		{m_pin, m_frc, m_rate, m_s1, m_s2, m_ist, m_imsk} = {32'd2, 32'd1, 160'd0};
		check_all();
		standby_rstn <= 1'b0;
		repeat (3) @(posedge clk);
		standby_rstn <= 1'b1;
		repeat (3) @(posedge clk);
		{m_en, m_flag, m_wsts, m_wen} = '0;
		check_all();
		report_and_stop();
	end
endmodule // tb
